// *** src/dscs_params.svh ***
// dscs_params.svh: codes, field values and timing figures of the sector command sequencer
// assumes a 125 MHz system clock and a bit-serial read stream from an external data separator
// Notes on behaviour
// RULE1: busy, head load, optional 15 ms settle
// RULE2: host loads sector before read/write command
// RULE3: compare track then sector; need good CRC
// RULE4: four revolutions without match gives record-missing
// RULE5: multi-record advances sector until end or abort
// RULE6: sector past track end sets record-missing
// RULE7: optional side compare, five index limit
// RULE8: size flag takes length from ID
// RULE9: side select output follows command flag
// RULE10: MFM marks preceded by three A1 syncs
// RULE11: data mark within 30/43 bytes of ID
// RULE12: each read byte loads holding register, requests
// RULE13: unread byte overwritten, lost-data set
// RULE14: data CRC error ends command, even multi
// RULE15: status bit 5 shows deleted data mark
// RULE16: write waits 11/22 bytes then gate or lost
// RULE17: write 6/12 zeros then selected mark
// RULE18: late write byte: lost-data, zero, continue
// RULE19: write CRC, one FF byte, drop gate
// RULE20: read address delivers six ID bytes
// RULE21: read address checks CRC, track to sector
// RULE22: read track index to index, no gate
// RULE23: refuse commands while drive not ready
// RULE24: length codes 0..3 mean 128..1024 bytes
`ifndef DSCS_PARAMS_SVH
`define DSCS_PARAMS_SVH
`define DSCS_CLK_MHZ 125
`define DSCS_SETTLE_MS 15
`define DSCS_REV_LIMIT 3'd4
`define DSCS_SIDE_IDX_LIMIT 3'd5
`define DSCS_DAM_WIN_FM 11'd30
`define DSCS_DAM_WIN_MFM 11'd43
`define DSCS_WR_GAP_FM 11'd11
`define DSCS_WR_GAP_MFM 11'd22
`define DSCS_ZERO_FM 11'd6
`define DSCS_ZERO_MFM 11'd12
`define DSCS_SYNC_CNT 2'd3
`define DSCS_SYNC_BYTE 8'ha1
`define DSCS_MARK_ID 8'hfe
`define DSCS_MARK_DATA 8'hfb
`define DSCS_MARK_DEL 8'hf8
`define DSCS_FILL_ONES 8'hff
`define DSCS_CRC_INIT 16'hffff
`define DSCS_CRC_POLY 16'h1021
`define DSCS_ID_BYTES 11'd6
`define DSCS_MIN_SECTOR 11'd128
`define DSCS_OMIT_BIT 3'd3
`endif

// *** src/dscs_pkg.sv ***
// dscs_pkg: command and state types of the sector command sequencer
// assumes nothing beyond a SystemVerilog elaborator
package dscs_pkg;
  typedef enum logic [1:0] {DSCS_RD_SECTOR, DSCS_WR_SECTOR, DSCS_RD_ADDR, DSCS_RD_TRACK} dscs_cmd_t;
  typedef enum logic [4:0] {
    ST_IDLE, ST_SETTLE, ST_HEAD, ST_SEARCH, ST_IDF, ST_DAM, ST_RDATA, ST_RCRC,
    ST_WGAP, ST_WZERO, ST_WSYNC, ST_WMARK, ST_WDATA, ST_WCRC, ST_WFF, ST_TWAIT, ST_TRUN
  } dscs_state_t;
endpackage

// *** src/dscs_crc16.sv ***
// dscs_crc16: byte-wide CRC-16 (x16+x12+x5+1) register for ID and data fields
// assumes init and en come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "dscs_params.svh"
module dscs_crc16 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc
);
  logic [15:0] base;
  logic [15:0] crc_nxt;

  always_comb begin
    base = init ? `DSCS_CRC_INIT : crc;
    crc_nxt = base;
    for (int i = 7; i >= 0; i--) begin
      if (crc_nxt[15] ^ din[i]) begin
        crc_nxt = {crc_nxt[14:0], 1'b0} ^ `DSCS_CRC_POLY;
      end else begin
        crc_nxt = {crc_nxt[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crc <= `DSCS_CRC_INIT;
    end else if (en) begin
      crc <= crc_nxt;
    end else if (init) begin
      crc <= `DSCS_CRC_INIT;
    end
  end
endmodule // dscs_crc16
`default_nettype wire

// *** src/dscs_sequencer.sv ***
// dscs_sequencer: sector and track command sequencer (read/write sector, read address/track)
// assumes a data separator delivering bits with a missing-clock flag, and a bit-cell tick
`timescale 1ns/1ps
`default_nettype none
`include "dscs_params.svh"
module dscs_sequencer import dscs_pkg::*; #(
  parameter int SETTLE_CYC = `DSCS_SETTLE_MS * `DSCS_CLK_MHZ * 1000,
  parameter logic [10:0] DEF_SECTOR_BYTES = 11'd256
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire dscs_cmd_t cmd_code,
  input wire logic settle_en,
  input wire logic multi_rec,
  input wire logic side_cmp_en,
  input wire logic side_expect,
  input wire logic size_from_id,
  input wire logic side_sel_flag,
  input wire logic mark_type_select,
  input wire logic force_int,
  input wire logic mfm_mode,
  input wire logic [7:0] track_reg,
  input wire logic sector_wr,
  input wire logic [7:0] sector_wdata,
  output logic [7:0] sector_reg,
  input wire logic [7:0] last_sector,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] data_holding_reg,
  output logic byte_service_request,
  input wire logic drive_ready_in,
  input wire logic index_in,
  input wire logic head_engaged_in,
  input wire logic rd_bit_in,
  input wire logic rd_bit_valid,
  input wire logic rd_clk_missing,
  output logic read_gate_out,
  input wire logic bit_tick,
  output logic wr_bit_out,
  output logic wr_clk_omit_out,
  output logic write_gate_out,
  output logic head_load_out,
  output logic side_select_out,
  output logic busy,
  output logic record_missing_flag,
  output logic crc_error,
  output logic lost_data,
  output logic record_type,
  output logic not_ready,
  output logic cmd_done
);
  localparam int CW = ($clog2(SETTLE_CYC + 1) > 11) ? $clog2(SETTLE_CYC + 1) : 11;

  // pin inputs: ready, index, head engaged; three stages, change taken when 2nd and 3rd agree
  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;
  logic ready_q, idx_q, head_q, idx_prev_r, idx_rise;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
      pin_q_r <= 3'h0;
      idx_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {drive_ready_in, index_in, head_engaged_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) pin_q_r[i] <= pin_s3_r[i];
      end
      idx_prev_r <= pin_q_r[1];
    end
  end
  assign ready_q = pin_q_r[2];
  assign idx_q = pin_q_r[1];
  assign head_q = pin_q_r[0];
  assign idx_rise = idx_q & ~idx_prev_r;

  dscs_state_t state_r;
  dscs_cmd_t cmd_r;
  logic [CW-1:0] cnt_r;
  logic [7:0] sr_r, sr_nxt, rx_byte_r, sector_r, dr_r;
  logic [7:0] id_r [0:3];
  logic [2:0] bcnt_r, idx_cnt_r, tx_bit_r;
  logic [1:0] a1_cnt_r;
  logic byte_rdy_r, rx_mark_r, sync_hit, am_hit, drq_r, done_r;
  logic multi_r, side_cmp_r, side_exp_r, size_r, mark_sel_r, side_miss_r, del_pend_r;
  logic head_r, sso_r, gate_r, rnf_r, crc_err_r, lost_r, rtype_r;
  logic [10:0] sec_len_r, id_len_bytes;
  logic [15:0] crc;
  logic [7:0] tx_sh_r, tx_next, mark_byte, crc_din;
  logic tx_a1_r, tx_end, tx_take, tx_more, gate_on, deliver, wr_req, sec_fin, accept;
  logic id_match, id_eval, crc_init, crc_en, in_hunt;

  assign accept = (state_r == ST_IDLE) & cmd_valid & ready_q;
  assign in_hunt = (state_r == ST_SEARCH) | (state_r == ST_DAM);

  // RULE10 byte alignment on A1 (MFM) or F8..FE (FM) with a missing clock
  assign sr_nxt = {sr_r[6:0], rd_bit_in};
  assign sync_hit = rd_clk_missing & (mfm_mode ? (sr_nxt == `DSCS_SYNC_BYTE) :
                    (sr_nxt >= `DSCS_MARK_DEL && sr_nxt != `DSCS_FILL_ONES));
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sr_r <= 8'h00;
      bcnt_r <= 3'd0;
      byte_rdy_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_mark_r <= 1'b0;
      a1_cnt_r <= 2'd0;
    end else begin
      byte_rdy_r <= 1'b0;
      if (rd_bit_valid) begin
        sr_r <= sr_nxt;
        if (sync_hit || bcnt_r == 3'd7) begin
          byte_rdy_r <= 1'b1;
          rx_byte_r <= sr_nxt;
          rx_mark_r <= sync_hit;
          bcnt_r <= 3'd0;
        end else begin
          bcnt_r <= bcnt_r + 3'd1;
        end
      end
      if (byte_rdy_r) begin
        if (rx_mark_r && rx_byte_r == `DSCS_SYNC_BYTE) begin
          a1_cnt_r <= (a1_cnt_r == `DSCS_SYNC_CNT) ? a1_cnt_r : a1_cnt_r + 2'd1;
        end else begin
          a1_cnt_r <= 2'd0;
        end
      end
    end
  end
  // RULE10 in MFM the mark is the byte after three A1 syncs
  assign am_hit = byte_rdy_r & (mfm_mode ? (a1_cnt_r == `DSCS_SYNC_CNT && !rx_mark_r) : rx_mark_r);

  // RULE24 length code n selects 128 << n bytes
  assign id_len_bytes = 11'(`DSCS_MIN_SECTOR << id_r[3][1:0]);
  // RULE3 track first, then sector
  assign id_match = (id_r[0] == track_reg) && (id_r[2] == sector_r) &&
                    !(side_cmp_r && id_r[1][0] != side_exp_r);
  assign id_eval = (state_r == ST_IDF) && cnt_r == CW'(`DSCS_ID_BYTES);
  assign wr_req = id_eval && cmd_r == DSCS_WR_SECTOR && id_match && crc == 16'h0000;
  // RULE20 six ID bytes delivered
  assign deliver = byte_rdy_r & (((state_r == ST_IDF) && cmd_r == DSCS_RD_ADDR &&
                   cnt_r < CW'(`DSCS_ID_BYTES)) || state_r == ST_RDATA || state_r == ST_TRUN);
  assign gate_on = (state_r == ST_WGAP) && cnt_r == CW'(mfm_mode ? `DSCS_WR_GAP_MFM :
                   `DSCS_WR_GAP_FM) && !drq_r;
  assign tx_end = gate_r & bit_tick & (tx_bit_r == 3'd7);
  assign mark_byte = mark_sel_r ? `DSCS_MARK_DEL : `DSCS_MARK_DATA;
  assign tx_take = tx_end & ((state_r == ST_WMARK) ||
                   (state_r == ST_WDATA && cnt_r != CW'(sec_len_r - 11'd1)));
  assign tx_more = (state_r == ST_WMARK) ? (sec_len_r > 11'd1) : (cnt_r < CW'(sec_len_r - 11'd2));
  assign sec_fin = ((state_r == ST_RCRC) && cnt_r == CW'(2) && crc == 16'h0000) ||
                   ((state_r == ST_WFF) && tx_end);

  // next byte for the write shifter, chosen at each byte boundary
  always_comb begin
    tx_next = 8'h00;
    case (state_r)
      // RULE17 zeros, then syncs or the selected mark
      ST_WZERO: if (cnt_r == CW'((mfm_mode ? `DSCS_ZERO_MFM : `DSCS_ZERO_FM) - 11'd1))
        tx_next = mfm_mode ? `DSCS_SYNC_BYTE : mark_byte;
      ST_WSYNC: tx_next = (cnt_r == CW'(2)) ? mark_byte : `DSCS_SYNC_BYTE;
      // RULE18 a late byte goes out as zero
      ST_WMARK: tx_next = drq_r ? 8'h00 : dr_r;
      ST_WDATA: tx_next = (cnt_r == CW'(sec_len_r - 11'd1)) ? crc[15:8] : (drq_r ? 8'h00 : dr_r);
      // RULE19 CRC low byte then all ones
      ST_WCRC: tx_next = (cnt_r == CW'(0)) ? crc[7:0] : `DSCS_FILL_ONES;
      default: tx_next = 8'h00;
    endcase
  end

  // CRC covers syncs and mark onward; MFM restarts on the first A1, FM on the mark
  assign crc_init = (byte_rdy_r & in_hunt & rx_mark_r & (!mfm_mode | a1_cnt_r == 2'd0)) |
                    (tx_end & (state_r == ST_WZERO) & (tx_next != 8'h00));
  assign crc_en = (byte_rdy_r & ((in_hunt & (rx_mark_r | am_hit)) |
                  ((state_r == ST_IDF) & cnt_r < CW'(`DSCS_ID_BYTES)) | (state_r == ST_RDATA) |
                  ((state_r == ST_RCRC) & cnt_r < CW'(2)))) |
                  (tx_end & (((state_r == ST_WZERO) & (tx_next != 8'h00)) |
                  (state_r == ST_WSYNC) | (state_r == ST_WMARK) | tx_take));
  assign crc_din = gate_r ? tx_next : rx_byte_r;
  dscs_crc16 u_crc (
    .clk(clk),
    .rst_b(rst_b),
    .init(crc_init),
    .en(crc_en),
    .din(crc_din),
    .crc(crc)
  );

  // write shifter, msb first, one bit per bit_tick while the gate is on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_sh_r <= 8'h00;
      tx_bit_r <= 3'd0;
      tx_a1_r <= 1'b0;
    end else if (gate_on) begin
      tx_sh_r <= 8'h00;
      tx_bit_r <= 3'd0;
      tx_a1_r <= 1'b0;
    end else if (tx_end) begin
      tx_sh_r <= tx_next;
      tx_bit_r <= 3'd0;
      tx_a1_r <= mfm_mode && tx_next == `DSCS_SYNC_BYTE &&
                 (state_r == ST_WZERO || state_r == ST_WSYNC);
    end else if (gate_r && bit_tick) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      tx_bit_r <= tx_bit_r + 3'd1;
    end
  end
  // RULE10 clock omitted between bits 4 and 5 of each written A1 sync
  assign wr_clk_omit_out = gate_r & tx_a1_r & (tx_bit_r == `DSCS_OMIT_BIT);

  // data holding register and its request; a new request wins over a host service
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dr_r <= 8'h00;
      drq_r <= 1'b0;
    end else begin
      // RULE12 assembled byte loads the holding register
      if (deliver) dr_r <= rx_byte_r;
      else if (host_wr) dr_r <= host_wdata;
      if (deliver || wr_req || (tx_take && tx_more)) drq_r <= 1'b1;
      else if (host_rd || host_wr || accept || state_r == ST_IDLE) drq_r <= 1'b0;
    end
  end

  // command sequence, status and sector register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cmd_r <= DSCS_RD_SECTOR;
      cnt_r <= '0;
      idx_cnt_r <= 3'd0;
      sector_r <= 8'h00;
      for (int i = 0; i < 4; i++) id_r[i] <= 8'h00;
      {multi_r, side_cmp_r, side_exp_r, size_r, mark_sel_r} <= 5'h00;
      {side_miss_r, del_pend_r, head_r, sso_r, gate_r} <= 5'h00;
      {rnf_r, crc_err_r, lost_r, rtype_r, done_r} <= 5'h00;
      sec_len_r <= DEF_SECTOR_BYTES;
    end else begin
      done_r <= 1'b0;
      if (sector_wr && state_r == ST_IDLE) sector_r <= sector_wdata;
      // RULE13 unread byte overwritten
      if (deliver && drq_r) lost_r <= 1'b1;
      // RULE18 late byte flagged, command continues
      if (tx_take && drq_r) lost_r <= 1'b1;
      if (force_int && state_r != ST_IDLE) begin
        state_r <= ST_IDLE;
        gate_r <= 1'b0;
        done_r <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: if (accept) begin
            // RULE1 busy and head load at accept
            head_r <= 1'b1;
            // RULE9 side select from the command
            sso_r <= side_sel_flag;
            cmd_r <= cmd_code;
            {multi_r, side_cmp_r, side_exp_r, size_r, mark_sel_r} <=
              {multi_rec, side_cmp_en, side_expect, size_from_id, mark_type_select};
            {rnf_r, crc_err_r, lost_r, rtype_r} <= 4'h0;
            cnt_r <= '0;
            state_r <= settle_en ? ST_SETTLE : ST_HEAD;
          end
          // RULE1 settle delay then poll head engaged
          ST_SETTLE: begin
            cnt_r <= cnt_r + CW'(1);
            if (cnt_r == CW'(SETTLE_CYC - 1)) state_r <= ST_HEAD;
          end
          ST_HEAD: if (head_q) begin
            idx_cnt_r <= 3'd0;
            side_miss_r <= 1'b0;
            state_r <= (cmd_r == DSCS_RD_TRACK) ? ST_TWAIT : ST_SEARCH;
          end
          ST_SEARCH: begin
            // RULE4 RULE7 revolution and side limits
            if (idx_rise) begin
              idx_cnt_r <= idx_cnt_r + 3'd1;
              if (idx_cnt_r + 3'd1 >= ((side_cmp_r && side_miss_r) ? `DSCS_SIDE_IDX_LIMIT :
                  `DSCS_REV_LIMIT)) begin
                rnf_r <= 1'b1;
                done_r <= 1'b1;
                state_r <= ST_IDLE;
              end
            end
            if (am_hit && rx_byte_r == `DSCS_MARK_ID) begin
              cnt_r <= '0;
              state_r <= ST_IDF;
            end
          end
          ST_IDF: if (id_eval) begin
            cnt_r <= '0;
            if (cmd_r == DSCS_RD_ADDR) begin
              // RULE21 CRC check, track into sector register
              crc_err_r <= (crc != 16'h0000);
              sector_r <= id_r[0];
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end else if (!id_match) begin
              // RULE7 side mismatch noted for the longer limit
              if (id_r[0] == track_reg && id_r[2] == sector_r) side_miss_r <= 1'b1;
              state_r <= ST_SEARCH;
            end else if (crc != 16'h0000) begin
              crc_err_r <= 1'b1;
              state_r <= ST_SEARCH;
            end else begin
              // RULE8 per-sector length from the ID
              sec_len_r <= size_r ? id_len_bytes : DEF_SECTOR_BYTES;
              state_r <= (cmd_r == DSCS_WR_SECTOR) ? ST_WGAP : ST_DAM;
            end
          end else if (byte_rdy_r) begin
            if (cnt_r < CW'(4)) id_r[cnt_r[1:0]] <= rx_byte_r;
            cnt_r <= cnt_r + CW'(1);
          end
          // RULE11 data mark window after ID CRC
          ST_DAM: if (am_hit && (rx_byte_r == `DSCS_MARK_DATA || rx_byte_r == `DSCS_MARK_DEL)) begin
            del_pend_r <= (rx_byte_r == `DSCS_MARK_DEL);
            cnt_r <= '0;
            state_r <= ST_RDATA;
          end else if (cnt_r == CW'(mfm_mode ? `DSCS_DAM_WIN_MFM : `DSCS_DAM_WIN_FM)) begin
            rnf_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end else if (byte_rdy_r) begin
            cnt_r <= cnt_r + CW'(1);
          end
          ST_RDATA: if (byte_rdy_r) begin
            cnt_r <= (cnt_r == CW'(sec_len_r - 11'd1)) ? '0 : cnt_r + CW'(1);
            if (cnt_r == CW'(sec_len_r - 11'd1)) state_r <= ST_RCRC;
          end
          ST_RCRC: if (cnt_r == CW'(2)) begin
            // RULE15 record type from the data mark
            rtype_r <= del_pend_r;
            // RULE14 data CRC error ends the command
            if (crc != 16'h0000) begin
              crc_err_r <= 1'b1;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end else if (byte_rdy_r) begin
            cnt_r <= cnt_r + CW'(1);
          end
          // RULE16 gap count then gate or lost data
          ST_WGAP: if (cnt_r == CW'(mfm_mode ? `DSCS_WR_GAP_MFM : `DSCS_WR_GAP_FM)) begin
            cnt_r <= '0;
            if (drq_r) begin
              lost_r <= 1'b1;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              gate_r <= 1'b1;
              state_r <= ST_WZERO;
            end
          end else if (byte_rdy_r) begin
            cnt_r <= cnt_r + CW'(1);
          end
          ST_WZERO: if (tx_end) begin
            cnt_r <= '0;
            if (tx_next == 8'h00) cnt_r <= cnt_r + CW'(1);
            else state_r <= mfm_mode ? ST_WSYNC : ST_WMARK;
          end
          ST_WSYNC: if (tx_end) begin
            cnt_r <= cnt_r + CW'(1);
            if (cnt_r == CW'(2)) state_r <= ST_WMARK;
          end
          ST_WMARK: if (tx_end) begin
            cnt_r <= '0;
            state_r <= ST_WDATA;
          end
          ST_WDATA: if (tx_end) begin
            cnt_r <= (cnt_r == CW'(sec_len_r - 11'd1)) ? '0 : cnt_r + CW'(1);
            if (cnt_r == CW'(sec_len_r - 11'd1)) state_r <= ST_WCRC;
          end
          ST_WCRC: if (tx_end) begin
            cnt_r <= cnt_r + CW'(1);
            if (cnt_r == CW'(1)) state_r <= ST_WFF;
          end
          // RULE19 gate drops after the FF byte
          ST_WFF: if (tx_end) gate_r <= 1'b0;
          // RULE22 index edge to index edge
          ST_TWAIT: if (idx_rise) state_r <= ST_TRUN;
          ST_TRUN: if (idx_rise) begin
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          default: state_r <= ST_IDLE;
        endcase
        // RULE5 RULE6 multi-record advance and track end
        if (sec_fin) begin
          cnt_r <= '0;
          idx_cnt_r <= 3'd0;
          if (!multi_r) begin
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            sector_r <= sector_r + 8'd1;
            if (sector_r >= last_sector) begin
              rnf_r <= 1'b1;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_SEARCH;
            end
          end
        end
      end
    end
  end

  assign busy = (state_r != ST_IDLE);
  // RULE23 not-ready refuses acceptance
  assign not_ready = ~ready_q;
  // RULE22 no read gate during read track
  assign read_gate_out = busy && cmd_r != DSCS_RD_TRACK && state_r >= ST_SEARCH && state_r <= ST_RCRC;
  assign sector_reg = sector_r;
  assign data_holding_reg = dr_r;
  assign byte_service_request = drq_r;
  assign wr_bit_out = tx_sh_r[7];
  assign write_gate_out = gate_r;
  assign head_load_out = head_r;
  assign side_select_out = sso_r;
  assign record_missing_flag = rnf_r;
  assign crc_error = crc_err_r;
  assign lost_data = lost_r;
  assign record_type = rtype_r;
  assign cmd_done = done_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_accept_busy_head: assert property (accept |=> busy && head_load_out) // RULE1
    else $error("accept did not raise busy and head load");
  chk_side_select: assert property (accept |=> side_select_out == $past(side_sel_flag)) // RULE9
    else $error("side select does not follow command");
  chk_no_settle: assert property (accept && !settle_en |=> state_r == ST_HEAD) // RULE1
    else $error("settle taken with settle flag clear");
  chk_refuse_unready: assert property ((state_r == ST_IDLE) && cmd_valid && !ready_q |=> !busy) // RULE23
    else $error("command accepted while not ready");
  chk_read_overrun: assert property (deliver && drq_r |=> lost_data) // RULE13
    else $error("overrun did not set lost data");
  chk_deliver_byte: assert property (deliver |=> byte_service_request &&
    data_holding_reg == $past(rx_byte_r)) // RULE12
    else $error("byte not delivered with request");
  chk_gate_release: assert property ((state_r == ST_WFF) && tx_end |=> !write_gate_out) // RULE19
    else $error("write gate held after fill byte");
  chk_track_no_rg: assert property (busy && cmd_r == DSCS_RD_TRACK |-> !read_gate_out) // RULE22
    else $error("read gate on during read track");
  chk_dam_window: assert property ((state_r == ST_DAM) |->
    cnt_r <= CW'(mfm_mode ? `DSCS_DAM_WIN_MFM : `DSCS_DAM_WIN_FM)) // RULE11
    else $error("data mark window overrun");
  chk_multi_end: assert property (sec_fin && multi_r && sector_r >= last_sector && !force_int
    |=> record_missing_flag && !busy) // RULE6
    else $error("track end did not set record missing");
  cov_read_done: cover property ((state_r == ST_RCRC) && sec_fin);
  cov_write_gate: cover property ($rose(write_gate_out));
  cov_track_done: cover property ((state_r == ST_TRUN) && idx_rise);
endmodule // dscs_sequencer
`default_nettype wire

// *** verif/dscs_drive_model.sv ***
// drive stand-in: read bit stream, index pulses, head engage
// assumes its tasks are called from the bench on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module dscs_drive_model (
  input wire logic clk,
  input wire logic head_load_out,
  output logic head_engaged_in,
  output logic index_in,
  output logic rd_bit_in,
  output logic rd_bit_valid,
  output logic rd_clk_missing
);
  initial {head_engaged_in, index_in, rd_bit_in, rd_bit_valid, rd_clk_missing} = 5'h00;
  always @(negedge clk) head_engaged_in <= head_load_out;
  // between bit cells the line shows the inverse, never a stale copy
  task automatic send_byte(input logic [7:0] b, input logic miss);
    for (int i = 7; i >= 0; i--) begin
      rd_bit_in = b[i];
      rd_bit_valid = 1'b1;
      // the separator flags a sync byte's missing clock with its last bit
      rd_clk_missing = miss && i == 0;
      @(negedge clk);
      {rd_bit_in, rd_bit_valid, rd_clk_missing} = {~b[i], 2'h0};
      repeat (3) @(negedge clk);
    end
  endtask
  task automatic index_pulse();
    index_in = 1'b1;
    repeat (8) @(negedge clk);
    index_in = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // dscs_drive_model
`default_nettype wire

// *** verif/tb_disk_sector_command_sequencer.sv ***
// bench: refusal, read address good and bad, search limit
// assumes the drive model feeds stream, index and head engage
`timescale 1ns/1ps
`default_nettype none
module tb_disk_sector_command_sequencer import dscs_pkg::*;;
  logic clk = 1'b0, rst_b, cmd_valid, settle_en, multi_rec, side_cmp_en, side_expect;
  logic size_from_id, side_sel_flag, mark_type_select, force_int, mfm_mode, sector_wr;
  logic host_rd, host_wr, drive_ready_in, index_in, head_engaged_in, rd_bit_in;
  logic rd_bit_valid, rd_clk_missing, read_gate_out, bit_tick, wr_bit_out, wr_clk_omit_out;
  logic write_gate_out, head_load_out, side_select_out, busy, record_missing_flag;
  logic crc_error, lost_data, record_type, not_ready, cmd_done, byte_service_request;
  logic [7:0] track_reg, sector_wdata, sector_reg, last_sector, host_wdata, data_holding_reg;
  dscs_cmd_t cmd_code;
  int n_fail = 0, total_checks = 0;
  dscs_sequencer #(.SETTLE_CYC(20)) i_dut (.*);
  dscs_drive_model drv (.*);
  always #4 clk = ~clk;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic start(input dscs_cmd_t c);
    cmd_code = c;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_done();
    for (int k = 0; k < 900 && cmd_done !== 1'b1; k++) @(negedge clk);
    check("done", cmd_done, 1'b1);
  endtask
  task automatic t_rd_addr(input logic bad);
    logic [7:0] id [6];
    logic [15:0] c;
    id = '{8'h05, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00};
    c = crc_upd(crc_upd(crc_upd(crc_upd(16'hffff, 8'ha1), 8'ha1), 8'ha1), 8'hfe);
    for (int i = 0; i < 4; i++) c = crc_upd(c, id[i]);
    id[4] = c[15:8];
    id[5] = c[7:0] ^ {7'h00, bad};
    side_sel_flag = !bad;
    start(DSCS_RD_ADDR);
    check("busy", busy, 1'b1);
    check("head load", head_load_out, 1'b1);
    check("side", side_select_out, side_sel_flag);
    repeat (40) @(negedge clk);
    fork
      begin
        // three syncs with missing clock ahead of the mark
        repeat (3) drv.send_byte(8'ha1, 1'b1);
        drv.send_byte(8'hfe, 1'b0);
        for (int i = 0; i < 6; i++) drv.send_byte(id[i], 1'b0);
        repeat (2) drv.send_byte(8'h4e, 1'b0);
      end
      begin
        for (int i = 0; i < 6; i++) begin
          for (int k = 0; k < 300 && byte_service_request !== 1'b1; k++) @(negedge clk);
          check("request", byte_service_request, 1'b1);
          check("id byte", data_holding_reg, id[i]);
          host_rd = 1'b1;
          @(negedge clk);
          host_rd = 1'b0;
        end
        // done stands one cycle, so watch for it while the trailer still streams
        wait_done();
      end
    join
    check("crc error", crc_error, bad);
    check("lost", lost_data, 1'b0);
    check("sector", sector_reg, 8'h05);
    $display("read address end");
  endtask
  initial begin
    {rst_b, cmd_valid, multi_rec, side_cmp_en, side_expect, size_from_id, force_int} = 7'h00;
    {mark_type_select, sector_wr, host_rd, host_wr, bit_tick, track_reg} = 13'h0000;
    {sector_wdata, last_sector, host_wdata} = 24'h00_0000;
    {settle_en, mfm_mode, side_sel_flag, drive_ready_in} = 4'h6;
    cmd_code = DSCS_RD_ADDR;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check("not ready", not_ready, 1'b1);
    start(DSCS_RD_SECTOR);
    check("refused", busy, 1'b0);
    drive_ready_in = 1'b1;
    repeat (8) @(negedge clk);
    check("ready", not_ready, 1'b0);
    $display("refusal end");
    t_rd_addr(1'b0);
    t_rd_addr(1'b1);
    // sector loaded before the sector command
    {sector_wr, sector_wdata} = 9'h103;
    @(negedge clk);
    sector_wr = 1'b0;
    start(DSCS_RD_SECTOR);
    repeat (40) @(negedge clk);
    repeat (3) drv.index_pulse();
    check("still busy", busy, 1'b1);
    fork
      drv.index_pulse();
      wait_done();
    join
    check("not found", record_missing_flag, 1'b1);
    $display("search limit end");
    end_sim();
  end
  // whole run is about a thousand cycles; this limit leaves wide margin
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule // tb_disk_sector_command_sequencer
`default_nettype wire
